// ===== design/fplc_ctrl.v
/*
  Perpendicular-mode, lock and parameter control for a floppy controller.
  Holds mode selects, per-drive flags, lock, configure parameters and the
  forced write-protect; times oscillator enable and write gate per Gap2
  byte. Assumes a byte-clock enable from the data path and a plain
  register port on the same 20 MHz clock.
*/
`timescale 1ns/1ns
`include "fplc_defs.vh"
//
// Contract
// - Any reset starts in conventional mode
// - Decode select pair into Gap2 lengths
// - Formatting at 1 Mbps perpendicular uses 41-byte Gap2
// - Oscillator enable at byte 24 or 43
// - Oscillator enable leaves two-byte sync margin
// - Conventional write gate rises at sync start
// - 1 Mbps perpendicular writes 38 Gap2 bytes
// - 500 Kbps perpendicular writes 19 Gap2 bytes
// - Per-drive flag makes drive perpendicular automatically
// - Per-drive Gap2 write count follows data rate
// - Per-drive perpendicular writes use zero precompensation
// - Conventional drives use programmed precompensation
// - Flags update only with overwrite enable set
// - Global select overrides per-drive flags
// - Software reset clears only global selects
// - Hardware reset clears selects and all flags
// - Lock keeps parameters through software reset
// - Hardware reset clears lock, restores parameter defaults
// - Lock command returns lock bit result byte
// - Dump byte eight carries lock and mode
// - Force bit shows write-protect active on both interfaces
// - Mode follows identity/format bits; hardware reset clears it
// - Defaults: FIFO off, threshold zero, track zero
module fplc_ctrl #(
  parameter PRECOMP_W = 3
) (
  // Clock and hardware reset
  input wire clk,
  input wire srst,
  // Register port
  input wire [`FPLC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata_r,
  // Data path sequencing
  input wire byte_tick,
  input wire gap2_start,
  input wire op_write,
  input wire op_format,
  input wire op_end,
  input wire [PRECOMP_W-1:0] precomp_prog,
  // Drive pins
  input wire drive_write_protect_input_n,
  input wire pport_write_protect_input_n,
  output reg write_gate_r,
  output reg oscillator_enable_r,
  output reg [PRECOMP_W-1:0] precomp_eff_r,
  output reg drive_wp_n_r,
  output reg pport_wp_n_r,
  // Status to the command engine
  output reg [5:0] gap2_fmt_len_r,
  output reg [7:0] lock_result_r,
  output reg [7:0] dump_byte8_r,
  output reg [7:0] precomp_start_track_r,
  output reg [3:0] fifo_threshold_param_r,
  output reg fifo_disable_param_r,
  output reg [1:0] compat_mode_r
);
  // ****************************************************************
  // State
  // ****************************************************************
  reg write_gate_timing_select_r; // Global write-gate select
  reg gap_select_r; // Global gap select
  reg [3:0] per_drive_perpendicular_flags_r; // One flag per drive
  reg lock_r; // Parameter protection
  reg force_write_protect_bit_r; // Write-protect override
  reg recording_format_bit_r; // Compatibility strap copy
  reg ident_bit_r; // Compatibility strap copy
  reg [1:0] rate_r; // Programmed data rate
  reg [1:0] drive_sel_r; // Active drive
  reg [5:0] byte_cnt_r; // Bytes since Gap2 start
  reg in_gap_r; // Gap2 sequence running
  reg hw_rst_seen_r; // First cycle after hardware reset

  // Pin synchroniser outputs
  wire drv_wp_n_s;
  wire pp_wp_n_s;

  // Decoder outputs
  wire [5:0] dec_fmt_len;
  wire [5:0] dec_wr_len;
  wire [5:0] dec_osc_byte;
  wire dec_zero_pc;

  // Command decode
  wire wr_perp = reg_wr && (reg_addr == `FPLC_OFF_PERP);
  wire wr_lock = reg_wr && (reg_addr == `FPLC_OFF_LOCK);
  wire wr_cfg = reg_wr && (reg_addr == `FPLC_OFF_CFG);
  wire wr_ctrl = reg_wr && (reg_addr == `FPLC_OFF_CTRL);
  wire sw_rst = wr_ctrl && reg_wdata[`FPLC_CTRL_SWRST];

  // Effective mode; globals win over drive flags
  wire [1:0] mode_sel = {write_gate_timing_select_r, gap_select_r};
  wire globals_zero = (mode_sel == `FPLC_MODE_CONV);
  wire sel_flag = per_drive_perpendicular_flags_r[drive_sel_r];
  wire per_drive_on = globals_zero && sel_flag;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Sync field begins two bytes after the oscillator enable byte of the current mode
  function [5:0] sync_start;
    input [5:0] osc_byte;
    begin
      sync_start = osc_byte + `FPLC_SYNC_MARGIN;
    end
  endfunction

  // Byte at which write gate rises for a write operation
  function [5:0] wg_start;
    input [5:0] osc_byte;
    input [5:0] wr_len;
    begin
      wg_start = sync_start(osc_byte) - wr_len;
    end
  endfunction

  // ****************************************************************
  // Submodules
  // ****************************************************************
  fplc_gap_decode u_dec (
    .mode(mode_sel),
    .per_drive(per_drive_on),
    .rate(rate_r),
    .gap2_fmt_len(dec_fmt_len),
    .gap2_wr_len(dec_wr_len),
    .osc_en_byte(dec_osc_byte),
    .zero_precomp(dec_zero_pc)
  );

  fplc_sync3 u_sync_drv (
    .clk(clk),
    .srst(srst),
    .d(drive_write_protect_input_n),
    .q_r(drv_wp_n_s)
  );

  fplc_sync3 u_sync_pp (
    .clk(clk),
    .srst(srst),
    .d(pport_write_protect_input_n),
    .q_r(pp_wp_n_s)
  );

  // ****************************************************************
  // Mode selects and per-drive flags
  // ****************************************************************
  // Software reset clears only the globals; flags need overwrite enable
  always @(posedge clk) begin
    if (srst) begin
      write_gate_timing_select_r <= 1'b0;
      gap_select_r <= 1'b0;
      per_drive_perpendicular_flags_r <= `FPLC_RST_FLG;
    end else if (sw_rst) begin
      write_gate_timing_select_r <= 1'b0;
      gap_select_r <= 1'b0;
    end else if (wr_perp) begin
      write_gate_timing_select_r <= reg_wdata[`FPLC_PERP_WGS];
      gap_select_r <= reg_wdata[`FPLC_PERP_GAP];
      if (reg_wdata[`FPLC_PERP_OW]) begin
        per_drive_perpendicular_flags_r <=
          reg_wdata[`FPLC_PERP_FLG_HI:`FPLC_PERP_FLG_LO];
      end
    end
  end

  // ****************************************************************
  // Lock and configure parameters
  // ****************************************************************
  // Locked parameters survive a software reset only
  always @(posedge clk) begin
    if (srst) begin
      lock_r <= 1'b0;
      fifo_disable_param_r <= `FPLC_RST_FDIS;
      fifo_threshold_param_r <= `FPLC_RST_THR;
      precomp_start_track_r <= `FPLC_RST_TRK;
      lock_result_r <= 8'h00;
    end else begin
      if (sw_rst && !lock_r) begin
        fifo_disable_param_r <= `FPLC_RST_FDIS;
        fifo_threshold_param_r <= `FPLC_RST_THR;
        precomp_start_track_r <= `FPLC_RST_TRK;
      end else if (wr_cfg) begin
        fifo_disable_param_r <= reg_wdata[`FPLC_CFG_FDIS];
        fifo_threshold_param_r <= reg_wdata[`FPLC_CFG_THR_HI:`FPLC_CFG_THR_LO];
        precomp_start_track_r <= reg_wdata[`FPLC_CFG_TRK_HI:`FPLC_CFG_TRK_LO];
      end
      if (wr_lock) begin
        lock_r <= reg_wdata[0];
        lock_result_r <= {3'h0, reg_wdata[0], 4'h0};
      end
    end
  end

  // ****************************************************************
  // Control: rate, drive select, force write-protect, straps
  // ****************************************************************
  // Straps are copied every cycle outside reset, one cycle late, never under reset
  always @(posedge clk) begin
    if (srst) begin
      force_write_protect_bit_r <= 1'b0;
      rate_r <= 2'h0;
      drive_sel_r <= 2'h0;
      recording_format_bit_r <= 1'b0;
      ident_bit_r <= 1'b0;
      hw_rst_seen_r <= 1'b1;
      compat_mode_r <= 2'h0;
    end else begin
      hw_rst_seen_r <= 1'b0;
      if (wr_ctrl) begin
        force_write_protect_bit_r <= reg_wdata[`FPLC_CTRL_FWP];
        recording_format_bit_r <= reg_wdata[`FPLC_CTRL_FMT];
        ident_bit_r <= reg_wdata[`FPLC_CTRL_IDENT];
        rate_r <= reg_wdata[`FPLC_CTRL_RATE_HI:`FPLC_CTRL_RATE_LO];
        drive_sel_r <= reg_wdata[`FPLC_CTRL_DRV_HI:`FPLC_CTRL_DRV_LO];
      end
      // Compatibility mode follows identity and format bits
      compat_mode_r <= {ident_bit_r, recording_format_bit_r};
    end
  end

  // ****************************************************************
  // Gap2 byte sequencer
  // ****************************************************************
  // Counts bytes from Gap2 start; ends at sync start or operation end
  always @(posedge clk) begin
    if (srst) begin
      byte_cnt_r <= 6'h00;
      in_gap_r <= 1'b0;
      write_gate_r <= 1'b0;
      oscillator_enable_r <= 1'b0;
    end else begin
      if (op_end) begin
        in_gap_r <= 1'b0;
        write_gate_r <= 1'b0;
        oscillator_enable_r <= 1'b0;
      end else if (gap2_start) begin
        in_gap_r <= 1'b1;
        byte_cnt_r <= 6'h00;
        write_gate_r <= 1'b0;
        oscillator_enable_r <= 1'b0;
      end else if (in_gap_r && byte_tick) begin
        byte_cnt_r <= byte_cnt_r + 6'h01;
        // Read back: oscillator on two bytes ahead of sync
        if (!op_write && !op_format && (byte_cnt_r + 6'h01 == dec_osc_byte)) begin
          oscillator_enable_r <= 1'b1;
        end
        // Write: gate early by the Gap2 portion written
        if (op_write && (byte_cnt_r + 6'h01 == wg_start(dec_osc_byte, dec_wr_len))) begin
          write_gate_r <= 1'b1;
        end
        if (byte_cnt_r + 6'h01 == sync_start(dec_osc_byte)) begin
          in_gap_r <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // Precompensation, write-protect and dump outputs
  // ****************************************************************
  // All outputs registered; write-protect forced low when override set
  always @(posedge clk) begin
    if (srst) begin
      precomp_eff_r <= {PRECOMP_W{1'b0}};
      drive_wp_n_r <= 1'b1;
      pport_wp_n_r <= 1'b1;
      gap2_fmt_len_r <= `FPLC_GAP2_STD;
      dump_byte8_r <= 8'h00;
    end else begin
      if (dec_zero_pc) begin
        precomp_eff_r <= {PRECOMP_W{1'b0}};
      end else begin
        precomp_eff_r <= precomp_prog;
      end
      drive_wp_n_r <= drv_wp_n_s && !force_write_protect_bit_r;
      pport_wp_n_r <= pp_wp_n_s && !force_write_protect_bit_r;
      gap2_fmt_len_r <= dec_fmt_len;
      // Lock, flags and selects packed for the dump
      dump_byte8_r <= {lock_r, per_drive_perpendicular_flags_r,
                       gap_select_r, write_gate_timing_select_r, 1'b0};
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  // Data valid the cycle after the strobe; unmapped reads return zero
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata_r <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FPLC_OFF_PERP: reg_rdata_r <= {24'h000000, 2'h0,
          per_drive_perpendicular_flags_r, write_gate_timing_select_r, gap_select_r};
        `FPLC_OFF_LOCK: reg_rdata_r <= {31'h00000000, lock_r};
        `FPLC_OFF_CFG: reg_rdata_r <= {19'h00000, fifo_disable_param_r,
          fifo_threshold_param_r, precomp_start_track_r};
        `FPLC_OFF_CTRL: reg_rdata_r <= {24'h000000, drive_sel_r, rate_r,
          ident_bit_r, recording_format_bit_r, force_write_protect_bit_r, 1'b0};
        default: reg_rdata_r <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_r <= 32'h00000000;
    end
  end
endmodule // fplc_ctrl

// ===== design/fplc_gap_decode.v
/*
  Combinational Gap2 and timing decoder for one effective mode.
  Assumes mode and data rate are stable registered values from the same clock.
*/
`timescale 1ns/1ns
`include "fplc_defs.vh"
module fplc_gap_decode (
  // Effective mode and rate
  input wire [1:0] mode,
  input wire per_drive,
  input wire [1:0] rate,
  // Decoded byte counts
  output reg [5:0] gap2_fmt_len,
  output reg [5:0] gap2_wr_len,
  output reg [5:0] osc_en_byte,
  output reg zero_precomp
);
  // ****************************************************************
  // Mode decode
  // ****************************************************************
  // Per-drive perpendicular follows the programmed rate
  always @* begin
    gap2_fmt_len = `FPLC_GAP2_STD;
    gap2_wr_len = `FPLC_GAP2_WR_CONV;
    osc_en_byte = `FPLC_OSC_CONV;
    zero_precomp = 1'b0;
    case (mode)
      `FPLC_MODE_P500: begin
        gap2_wr_len = `FPLC_GAP2_WR_P500;
      end
      `FPLC_MODE_P1M: begin
        gap2_fmt_len = `FPLC_GAP2_P1M_FMT;
        gap2_wr_len = `FPLC_GAP2_WR_P1M;
        osc_en_byte = `FPLC_OSC_P1M;
      end
      default: begin
        // Conventional and reserved code behave alike
        if (per_drive) begin
          zero_precomp = 1'b1;
          if (rate == `FPLC_RATE_1M) begin
            gap2_fmt_len = `FPLC_GAP2_P1M_FMT;
            gap2_wr_len = `FPLC_GAP2_WR_P1M;
            osc_en_byte = `FPLC_OSC_P1M;
          end else begin
            gap2_wr_len = `FPLC_GAP2_WR_P500;
          end
        end
      end
    endcase
  end
endmodule // fplc_gap_decode

// ===== design/fplc_sync3.v
/*
  Three-flop input synchroniser with agreement filter.
  Assumes an asynchronous pin level on d and the block clock on clk.
*/
`timescale 1ns/1ns
module fplc_sync3 (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Pin level in, filtered level out
  input wire d,
  output reg q_r
);
  // Flop chain; stage 0 feeds only stage 1
  reg s0_r;
  reg s1_r;
  reg s2_r;

  // ****************************************************************
  // Chain and agreement filter
  // ****************************************************************
  // Output follows only when stages 1 and 2 agree
  always @(posedge clk) begin
    if (srst) begin
      s0_r <= 1'b1;
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      q_r <= 1'b1;
    end else begin
      s0_r <= d;
      s1_r <= s0_r;
      s2_r <= s1_r;
      if (s1_r == s2_r) begin
        q_r <= s2_r;
      end
    end
  end
endmodule // fplc_sync3

// ===== dv/fplc_ctrl_props.sv
/*
  Checker for the perpendicular-mode and lock control block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
module fplc_ctrl_props #(
  parameter PRECOMP_W = 3
) (
  // Clock and reset
  input wire clk,
  input wire srst,
  // Gap sequencing
  input wire byte_tick,
  input wire gap2_start,
  input wire op_end,
  input wire [PRECOMP_W-1:0] precomp_prog,
  input wire drive_write_protect_input_n,
  // Observed outputs
  input wire write_gate_r,
  input wire oscillator_enable_r,
  input wire [PRECOMP_W-1:0] precomp_eff_r,
  input wire drive_wp_n_r,
  input wire [5:0] gap2_fmt_len_r,
  input wire [7:0] lock_result_r,
  input wire [7:0] dump_byte8_r,
  input wire [7:0] precomp_start_track_r,
  input wire [3:0] fifo_threshold_param_r,
  input wire fifo_disable_param_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  reg [5:0] tick_cnt_r; // Bytes since Gap2 start, saturating

  // Byte counter mirrors the controller's own Gap2 count
  always @(posedge clk) begin
    if (srst || gap2_start)
      tick_cnt_r <= 6'h00;
    else if (byte_tick && tick_cnt_r != 6'h3F)
      tick_cnt_r <= tick_cnt_r + 6'h01;
  end

  chk_hw_defaults: assert property ($past(srst) |-> fifo_disable_param_r &&
    fifo_threshold_param_r == 4'h0 && precomp_start_track_r == 8'h00)
    else $error("parameter defaults missing after reset");
  chk_hw_clear: assert property ($past(srst) |-> dump_byte8_r == 8'h00 &&
    lock_result_r == 8'h00) else $error("mode or lock kept over reset");
  chk_fmt_len: assert property (gap2_fmt_len_r == 6'h29 |->
    dump_byte8_r[2:1] == 2'h3 || dump_byte8_r[6:3] != 4'h0)
    else $error("long Gap2 outside 1M mode");
  chk_osc_point: assert property ($rose(oscillator_enable_r) |->
    tick_cnt_r == 6'h18 || tick_cnt_r == 6'h2B) else $error("osc enable byte off");
  chk_gate_point: assert property ($rose(write_gate_r) |->
    tick_cnt_r == 6'h1A || tick_cnt_r == 6'h07) else $error("write gate byte off");
  chk_op_end: assert property (op_end |=> !write_gate_r && !oscillator_enable_r)
    else $error("gate still up after end of op");
  chk_precomp_src: assert property (precomp_eff_r != 0 |->
    precomp_eff_r == $past(precomp_prog)) else $error("precomp not programmed value");
  chk_lock_echo: assert property ($past(lock_result_r) == {3'h0, dump_byte8_r[7], 4'h0})
    else $error("lock result and dump disagree");
  chk_wp_pin: assert property (!drive_write_protect_input_n [*7] |-> !drive_wp_n_r)
    else $error("active pin not shown");

  // Main scenarios reached
  cov_gate: cover property ($rose(write_gate_r));
  cov_osc: cover property ($rose(oscillator_enable_r));
  cov_fmt41: cover property (gap2_fmt_len_r == 6'h29);
  cov_lock: cover property (lock_result_r[4]);
endmodule // fplc_ctrl_props

bind fplc_ctrl fplc_ctrl_props #(.PRECOMP_W(PRECOMP_W)) i_props (.*);

// ===== dv/fplc_drive_model.sv
/*
  Drive-side model: byte clock, Gap2 start, end of op, write-protect pins,
  and the byte index at which write gate and oscillator enable rose.
  Assumes the controller clock and a one-cycle go pulse from the bench.
*/
`timescale 1ns/1ns
module fplc_drive_model (
  // Clock and bench control
  input wire clk,
  input wire go,
  input wire wp_lvl_n,
  // Toward the controller
  output reg byte_tick = 1'b0,
  output reg gap2_start = 1'b0,
  output reg op_end = 1'b0,
  output wire drive_wp_n,
  output wire pport_wp_n,
  // From the controller
  input wire write_gate_r,
  input wire oscillator_enable_r,
  // Byte index at which each line rose
  output reg [7:0] wg_at = 8'h00,
  output reg [7:0] osc_at = 8'h00
);
  reg [7:0] cnt_r = 8'h00; // Bytes since Gap2 start
  reg [1:0] div_r = 2'h0; // One byte every four clocks
  reg busy_r = 1'b0; // Inside a sector pass

  // Pins have pull-ups, so the level follows the bench directly
  assign drive_wp_n = wp_lvl_n;
  assign pport_wp_n = wp_lvl_n;

  // Byte sequencer: 50 bytes per pass, then end of op
  always @(posedge clk) begin
    gap2_start <= go;
    byte_tick <= 1'b0;
    op_end <= 1'b0;
    div_r <= div_r + 2'h1;
    if (go) begin
      busy_r <= 1'b1;
      cnt_r <= 8'h00;
      div_r <= 2'h0;
    end else if (busy_r && div_r == 2'h3) begin
      if (cnt_r == 8'h32) begin
        busy_r <= 1'b0;
        op_end <= 1'b1;
      end else begin
        byte_tick <= 1'b1;
        cnt_r <= cnt_r + 8'h01;
      end
    end
    // Ticks are four clocks apart, so output latency never shifts the index
    if (go)
      wg_at <= 8'h00;
    else if (busy_r && write_gate_r && wg_at == 8'h00)
      wg_at <= cnt_r;
    if (go)
      osc_at <= 8'h00;
    else if (busy_r && oscillator_enable_r && osc_at == 8'h00)
      osc_at <= cnt_r;
  end
endmodule // fplc_drive_model

// ===== dv/tb.sv
/*
  Self-checking bench: expectations queued by the driver, compared by a
  watcher when read data or a probed output appears.
  Assumes the drive model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ns
`include "fplc_defs.vh"
module tb;
  reg clk = 1'b0;
  reg srst = 1'b1; // Hardware reset, held at start
  reg [3:0] reg_addr = 4'h0;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg op_write = 1'b0;
  reg op_format = 1'b0;
  reg [2:0] precomp_prog = 3'h0;
  reg go = 1'b0; // Starts one drive pass
  reg wp_lvl_n = 1'b1;
  reg obs_v = 1'b0; // Probe request to the watcher
  reg [3:0] obs_sel = 4'h0;
  reg rd_prev = 1'b0;
  reg [31:0] obs_val;
  reg [31:0] exp_q [$]; // Expectations, oldest first
  reg [31:0] cfg;
  reg [2:0] pc;
  integer seed = 11;
  integer err_total = 0;
  integer comparisons = 0;
  integer m;
  wire [31:0] reg_rdata_r;
  wire byte_tick, gap2_start, op_end, write_gate_r, oscillator_enable_r;
  wire drive_write_protect_input_n, pport_write_protect_input_n;
  wire drive_wp_n_r, pport_wp_n_r, fifo_disable_param_r;
  wire [2:0] precomp_eff_r;
  wire [5:0] gap2_fmt_len_r;
  wire [7:0] lock_result_r, dump_byte8_r, precomp_start_track_r, wg_at, osc_at;
  wire [3:0] fifo_threshold_param_r;
  wire [1:0] compat_mode_r;

  always #25 clk = ~clk;

  fplc_ctrl #(.PRECOMP_W(3)) i_dut (.*);

  fplc_drive_model i_drive (.clk(clk), .go(go), .wp_lvl_n(wp_lvl_n), .byte_tick(byte_tick),
    .gap2_start(gap2_start), .op_end(op_end),
    .drive_wp_n(drive_write_protect_input_n), .pport_wp_n(pport_write_protect_input_n),
    .write_gate_r(write_gate_r), .oscillator_enable_r(oscillator_enable_r),
    .wg_at(wg_at), .osc_at(osc_at));

  // Probe mux; the config word keeps the register's own field layout
  always @* begin
    case (obs_sel)
      4'h0: obs_val = {24'h0, lock_result_r};
      4'h1: obs_val = {24'h0, dump_byte8_r};
      4'h2: obs_val = {26'h0, gap2_fmt_len_r};
      4'h3: obs_val = {19'h0, fifo_disable_param_r, fifo_threshold_param_r,
                       precomp_start_track_r};
      4'h4: obs_val = {29'h0, precomp_eff_r};
      4'h5: obs_val = {30'h0, drive_wp_n_r, pport_wp_n_r};
      4'h6: obs_val = {30'h0, compat_mode_r};
      4'h7: obs_val = {24'h0, wg_at};
      default: obs_val = {24'h0, osc_at};
    endcase
  end

  // ********
  // Comparison and verdict
  // ********
  task check(input [31:0] seen, input [31:0] want);
    begin
      comparisons = comparisons + 1;
      if (seen !== want) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: seen %h want %h", $time, seen, want);
      end
    end
  endtask

  task test_done;
    begin
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  // Watcher: read data stands only the cycle after the strobe
  always @(posedge clk) begin
    rd_prev <= reg_rd;
    if (rd_prev || obs_v)
      check(rd_prev ? reg_rdata_r : obs_val, exp_q.pop_front());
  end

  // ********
  // Bus and drive tasks; an idle edge follows each strobe
  // ********
  task wr(input [3:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
    end
  endtask

  task rd(input [3:0] a, input [31:0] want);
    begin
      exp_q.push_back(want);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
    end
  endtask

  task probe(input [3:0] sel, input [31:0] want);
    begin
      exp_q.push_back(want);
      obs_sel <= sel;
      obs_v <= 1'b1;
      @(posedge clk);
      obs_v <= 1'b0;
      @(posedge clk);
    end
  endtask

  // One sector pass, bounded wait for end of op, then probe
  task run(input wop, input [3:0] sel, input [31:0] want);
    integer n;
    begin
      op_write <= wop;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (n = 0; n < 400 && op_end !== 1'b1; n = n + 1)
        @(posedge clk);
      probe(sel, want);
    end
  endtask

  // Hang guard: the whole test takes a few thousand cycles
  initial begin
    #(50 * 20000);
    err_total = err_total + 1;
    test_done;
  end

  // ********
  // Main sequence
  // ********
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    pc = $random(seed);
    pc = pc | 3'h1; // Nonzero so a zeroed precomp shows
    precomp_prog <= pc;
    cfg = $random(seed) & 32'h1FFF;
    @(posedge clk);
    probe(4'h0, 32'h0);
    probe(4'h2, 32'h16);
    probe(4'h3, 32'h1000);
    wr(`FPLC_OFF_CFG, cfg);
    wr(`FPLC_OFF_LOCK, 32'h1);
    rd(`FPLC_OFF_LOCK, 32'h1);
    probe(4'h0, 32'h10);
    wr(4'h2, 32'hFFFFFFFF);
    rd(4'h2, 32'h0);
    // Every mode code, rate kept in step with the mode
    for (m = 0; m < 4; m = m + 1) begin
      wr(`FPLC_OFF_CTRL, (m == 3) ? 32'h30 : 32'h20);
      wr(`FPLC_OFF_PERP, m);
      probe(4'h2, (m == 3) ? 32'h29 : 32'h16);
      run(1'b1, 4'h7, (m == 1 || m == 3) ? 32'h7 : 32'h1A);
      run(1'b0, 4'h8, (m == 3) ? 32'h2B : 32'h18);
    end
    // Drive 2 flagged perpendicular, conventional globally
    wr(`FPLC_OFF_PERP, 32'h90);
    wr(`FPLC_OFF_CTRL, 32'hB0);
    run(1'b1, 4'h7, 32'h7);
    run(1'b0, 4'h8, 32'h2B);
    probe(4'h4, 32'h0);
    wr(`FPLC_OFF_CTRL, 32'h30);
    probe(4'h4, {29'h0, pc});
    run(1'b1, 4'h7, 32'h1A);
    wr(`FPLC_OFF_PERP, 32'h00);
    probe(4'h1, 32'hA0);
    // Global 1M mode overrides the flag of drive 2
    wr(`FPLC_OFF_PERP, 32'h03);
    wr(`FPLC_OFF_CTRL, 32'hB0);
    probe(4'h1, 32'hA6);
    probe(4'h4, {29'h0, pc});
    // Software reset while locked, then unlocked
    wr(`FPLC_OFF_CTRL, 32'hB1);
    probe(4'h1, 32'hA0);
    probe(4'h3, cfg);
    wr(`FPLC_OFF_LOCK, 32'h0);
    wr(`FPLC_OFF_CTRL, 32'h01);
    probe(4'h3, 32'h1000);
    // Forced write protect, then the pin itself
    wr(`FPLC_OFF_CTRL, 32'h02);
    repeat (6) @(posedge clk);
    probe(4'h5, 32'h0);
    wr(`FPLC_OFF_CTRL, 32'h08);
    repeat (6) @(posedge clk);
    probe(4'h5, 32'h3);
    probe(4'h6, 32'h2);
    wp_lvl_n <= 1'b0;
    repeat (7) @(posedge clk);
    probe(4'h5, 32'h0);
    wp_lvl_n <= 1'b1;
    // Mid-run hardware reset with lock and flags set
    wr(`FPLC_OFF_LOCK, 32'h1);
    wr(`FPLC_OFF_CFG, cfg);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    probe(4'h1, 32'h0);
    probe(4'h3, 32'h1000);
    probe(4'h6, 32'h0);
    test_done;
  end
endmodule // tb

// ===== shared/fplc_defs.vh
/*
  Constants for the perpendicular-mode and lock control block:
  register offsets, field positions, reset values and gap byte counts.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef FPLC_DEFS_VH
`define FPLC_DEFS_VH

// ****************************************************************
// Register offsets (byte addresses, word aligned)
// ****************************************************************
`define FPLC_ADDR_W 4
`define FPLC_OFF_PERP 4'h0
`define FPLC_OFF_LOCK 4'h4
`define FPLC_OFF_CFG 4'h8
`define FPLC_OFF_CTRL 4'hC

// ****************************************************************
// Perpendicular register fields
// ****************************************************************
`define FPLC_PERP_GAP 0
`define FPLC_PERP_WGS 1
`define FPLC_PERP_FLG_LO 2
`define FPLC_PERP_FLG_HI 5
`define FPLC_PERP_OW 7

// ****************************************************************
// Config register fields: precomp track [7:0], threshold [11:8], fifo dis [12]
// ****************************************************************
`define FPLC_CFG_TRK_LO 0
`define FPLC_CFG_TRK_HI 7
`define FPLC_CFG_THR_LO 8
`define FPLC_CFG_THR_HI 11
`define FPLC_CFG_FDIS 12

// ****************************************************************
// Control register fields
// ****************************************************************
`define FPLC_CTRL_SWRST 0
`define FPLC_CTRL_FWP 1
`define FPLC_CTRL_FMT 2
`define FPLC_CTRL_IDENT 3
`define FPLC_CTRL_RATE_LO 4
`define FPLC_CTRL_RATE_HI 5
`define FPLC_CTRL_DRV_LO 6
`define FPLC_CTRL_DRV_HI 7

// ****************************************************************
// Reset values
// ****************************************************************
`define FPLC_RST_FDIS 1'h1
`define FPLC_RST_THR 4'h0
`define FPLC_RST_TRK 8'h00
`define FPLC_RST_SEL 2'h0
`define FPLC_RST_FLG 4'h0

// ****************************************************************
// Mode codes {write_gate_timing_select, gap}
// ****************************************************************
`define FPLC_MODE_CONV 2'h0
`define FPLC_MODE_P500 2'h1
`define FPLC_MODE_RSVD 2'h2
`define FPLC_MODE_P1M 2'h3

// ****************************************************************
// Gap2 byte counts
// ****************************************************************
`define FPLC_GAP2_STD 6'h16
`define FPLC_GAP2_P1M_FMT 6'h29
`define FPLC_GAP2_WR_CONV 6'h00
`define FPLC_GAP2_WR_P500 6'h13
`define FPLC_GAP2_WR_P1M 6'h26
`define FPLC_OSC_CONV 6'h18
`define FPLC_OSC_P1M 6'h2B
`define FPLC_SYNC_MARGIN 6'h02

// Data rate code for 1 Mbps in the control rate field
`define FPLC_RATE_1M 2'h3

`endif
